/* File: hdl/cce_top.sv */
`timescale 1ns/100ps
`default_nettype none
module cce_top (
    input  wire logic       core_clk_in,
    input  wire logic       arst_n_in,
    input  wire logic       start_in,
    input  wire logic [7:0] opcode_in,
    input  wire logic [7:0] dst_in,
    input  wire logic [7:0] src_in,
    input  wire logic [7:0] ptr_in,
    input  wire logic [7:0] jump_offset_in,
    input  wire logic [7:0] flags_in,
    input  wire logic [15:0] next_pc_in,
    output logic            busy_out,
    output logic            done_out,
    output logic            illegal_out,
    output logic [7:0]      dst_data_out,
    output logic            dst_we_out,
    output logic [7:0]      ptr_data_out,
    output logic            ptr_we_out,
    output logic [7:0]      flags_data_out,
    output logic [7:0]      flags_addr_out,
    output logic            flags_we_out,
    output logic [15:0]     pc_out,
    output logic            pc_load_out,
    output logic [1:0]      instr_len_out
);
    cce_res_if res ();
    cce_pkg::cce_state_t state_r, state_nxt;
    logic [4:0]  cnt_r, cnt_nxt;
    logic [7:0]  op_r, op_nxt, dst_r, dst_nxt, src_r, src_nxt;
    logic [7:0]  ptr_r, ptr_nxt, off_r, off_nxt, fl_r, fl_nxt;
    logic [15:0] npc_r, npc_nxt;
    logic [7:0]  dd_r, dd_nxt, pd_r, pd_nxt, fd_r, fd_nxt;
    logic [15:0] pc_r, pc_nxt;
    logic        dwe_r, dwe_nxt, pwe_r, pwe_nxt, fwe_r, fwe_nxt;
    logic        pcl_r, pcl_nxt, ill_r, ill_nxt;
    logic [1:0]  len_r, len_nxt;
    logic        known, is_com, is_ess, is_cmp_l;
    logic [4:0]  cycles;

    cce_alu u_alu (
        .opcode_in (op_r),
        .dst_in    (dst_r),
        .src_in    (src_r),
        .flags_in  (fl_r),
        .res       (res)
    );

    // decode of accepted encodings; anything else is flagged illegal
    always_comb begin
        is_com = (opcode_in == cce_pkg::OP_COM_R) ||
                 (opcode_in == cce_pkg::OP_COM_PTR);
        is_ess = (opcode_in == cce_pkg::OP_ESS);
        is_cmp_l = (opcode_in == cce_pkg::OP_CMP_RPTR) ||
                   (opcode_in == cce_pkg::OP_CMP_GR) ||
                   (opcode_in == cce_pkg::OP_CMP_GPTR) ||
                   (opcode_in == cce_pkg::OP_CMP_LIT);
        known = is_com || is_ess || is_cmp_l ||
                (opcode_in == cce_pkg::OP_CMP_RR);
        if (is_com) begin
            len_nxt = cce_pkg::LEN_COM;
        end else if (opcode_in == cce_pkg::OP_CMP_RR ||
                     opcode_in == cce_pkg::OP_CMP_RPTR) begin
            len_nxt = cce_pkg::LEN_CMP_S;
        end else begin
            len_nxt = cce_pkg::LEN_3;
        end
        if (!(start_in && state_r == cce_pkg::CCE_IDLE && known)) begin
            len_nxt = len_r;
        end
    end

    // cycle budget of the running instruction, branch outcome included
    always_comb begin
        if (op_r == cce_pkg::OP_COM_R || op_r == cce_pkg::OP_COM_PTR) begin
            cycles = cce_pkg::CYC_COM;
        end else if (op_r == cce_pkg::OP_CMP_RR) begin
            cycles = cce_pkg::CYC_CMP_S;
        end else if (op_r == cce_pkg::OP_ESS) begin
            cycles = res.equal ? cce_pkg::CYC_ESS_T
                               : cce_pkg::CYC_ESS_N;
        end else begin
            cycles = cce_pkg::CYC_CMP_L;
        end
    end

    // sequencer: captures operands, counts cycles, commits on last one
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        op_nxt = op_r;
        dst_nxt = dst_r;
        src_nxt = src_r;
        ptr_nxt = ptr_r;
        off_nxt = off_r;
        fl_nxt = fl_r;
        npc_nxt = npc_r;
        dd_nxt = dd_r;
        pd_nxt = pd_r;
        fd_nxt = fd_r;
        pc_nxt = pc_r;
        dwe_nxt = 1'b0;
        pwe_nxt = 1'b0;
        fwe_nxt = 1'b0;
        pcl_nxt = 1'b0;
        ill_nxt = 1'b0;
        case (state_r)
            cce_pkg::CCE_IDLE: begin
                if (start_in && known) begin
                    state_nxt = cce_pkg::CCE_BUSY;
                    cnt_nxt = 5'h01;
                    op_nxt = opcode_in;
                    dst_nxt = dst_in;
                    src_nxt = src_in;
                    ptr_nxt = ptr_in;
                    off_nxt = jump_offset_in;
                    fl_nxt = flags_in;
                    npc_nxt = next_pc_in;
                end else if (start_in) begin
                    ill_nxt = 1'b1;
                end
            end
            cce_pkg::CCE_BUSY: begin
                cnt_nxt = cnt_r + 5'h01;
                // commit one cycle early so done lands on the last cycle
                if (cnt_r == cycles - 5'h01) begin
                    state_nxt = cce_pkg::CCE_DONE;
                    if (op_r == cce_pkg::OP_ESS) begin
                        // pointer advances taken or not
                        pd_nxt = ptr_r + 8'h01;
                        pwe_nxt = 1'b1;
                        if (res.equal) begin
                            // sign-extended offset from next address
                            pc_nxt = npc_r +
                                {{8{off_r[7]}}, off_r};
                            pcl_nxt = 1'b1;
                        end
                        // flags untouched
                    end else begin
                        fd_nxt = res.flags;
                        fwe_nxt = 1'b1;
                        dd_nxt = res.result;
                        dwe_nxt = res.wr_dst;
                    end
                end
            end
            cce_pkg::CCE_DONE: begin
                state_nxt = cce_pkg::CCE_IDLE;
            end
            default: begin
                state_nxt = cce_pkg::CCE_IDLE;
            end
        endcase
    end

    // registers of the sequencer
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_r <= cce_pkg::CCE_IDLE;
            cnt_r <= 5'h00;
            op_r <= 8'h00;
            dst_r <= 8'h00;
            src_r <= 8'h00;
            ptr_r <= 8'h00;
            off_r <= 8'h00;
            fl_r <= 8'h00;
            npc_r <= 16'h0000;
            dd_r <= 8'h00;
            pd_r <= 8'h00;
            fd_r <= 8'h00;
            pc_r <= 16'h0000;
            dwe_r <= 1'b0;
            pwe_r <= 1'b0;
            fwe_r <= 1'b0;
            pcl_r <= 1'b0;
            ill_r <= 1'b0;
            len_r <= 2'h0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            op_r <= op_nxt;
            dst_r <= dst_nxt;
            src_r <= src_nxt;
            ptr_r <= ptr_nxt;
            off_r <= off_nxt;
            fl_r <= fl_nxt;
            npc_r <= npc_nxt;
            dd_r <= dd_nxt;
            pd_r <= pd_nxt;
            fd_r <= fd_nxt;
            pc_r <= pc_nxt;
            dwe_r <= dwe_nxt;
            pwe_r <= pwe_nxt;
            fwe_r <= fwe_nxt;
            pcl_r <= pcl_nxt;
            ill_r <= ill_nxt;
            len_r <= len_nxt;
        end
    end

    // outputs from flops or decodes of state_r; the flags address is a constant
    assign busy_out = (state_r != cce_pkg::CCE_IDLE);
    assign done_out = (state_r == cce_pkg::CCE_DONE);
    assign illegal_out = ill_r;
    assign dst_data_out = dd_r;
    assign dst_we_out = dwe_r;
    assign ptr_data_out = pd_r;
    assign ptr_we_out = pwe_r;
    assign flags_data_out = fd_r;
    assign flags_addr_out = cce_pkg::FLAGS_ADDR;
    assign flags_we_out = fwe_r;
    assign pc_out = pc_r;
    assign pc_load_out = pcl_r;
    assign instr_len_out = len_r;

    // invert writes complement of captured destination
    property p_com_inv;
        @(posedge core_clk_in) disable iff (!arst_n_in)
        (dst_we_out) |-> (dst_data_out == ~dst_r);
    endproperty
    a_com_inv: assert property (p_com_inv)
        else $error("bad invert");

    property p_com_flags;
        @(posedge core_clk_in) disable iff (!arst_n_in)
        (dst_we_out) |-> (!flags_data_out[cce_pkg::FL_V] &&
            flags_data_out[cce_pkg::FL_Z] == (dst_data_out == 8'h00) &&
            flags_data_out[cce_pkg::FL_S] ==
                dst_data_out[cce_pkg::SIGN_BIT] &&
            flags_data_out[cce_pkg::FL_C] == fl_r[cce_pkg::FL_C]);
    endproperty
    a_com_flags: assert property (p_com_flags)
        else $error("bad invert flags");

    property p_cmp_nowrite;
        @(posedge core_clk_in) disable iff (!arst_n_in)
        (flags_we_out && op_r[7:4] == cce_pkg::OP_CMP_RR[7:4]) |->
        !dst_we_out;
    endproperty
    a_cmp_nowrite: assert property (p_cmp_nowrite)
        else $error("compare wrote destination");

    property p_cmp_carry;
        @(posedge core_clk_in) disable iff (!arst_n_in)
        (flags_we_out && op_r[7:4] == cce_pkg::OP_CMP_RR[7:4]) |->
        (flags_data_out[cce_pkg::FL_C] == (src_r > dst_r));
    endproperty
    a_cmp_carry: assert property (p_cmp_carry)
        else $error("bad carry");

    property p_cmp_zero;
        @(posedge core_clk_in) disable iff (!arst_n_in)
        (flags_we_out && op_r[7:4] == cce_pkg::OP_CMP_RR[7:4]) |->
        (flags_data_out[cce_pkg::FL_Z] == (src_r == dst_r));
    endproperty
    a_cmp_zero: assert property (p_cmp_zero)
        else $error("bad zero");

    // done stands in cycle n, so it is sampled n edges after the start edge
    property p_cmp_six;
        @(posedge core_clk_in) disable iff (!arst_n_in)
        (start_in && !busy_out && opcode_in == cce_pkg::OP_CMP_LIT) |->
        ##6 done_out;
    endproperty
    a_cmp_six: assert property (p_cmp_six)
        else $error("compare not six cycles");

    property p_ess_ptr;
        @(posedge core_clk_in) disable iff (!arst_n_in)
        (ptr_we_out) |-> (ptr_data_out == ptr_r + 8'h01 && !flags_we_out);
    endproperty
    a_ess_ptr: assert property (p_ess_ptr)
        else $error("bad pointer");

    property p_ess_taken;
        @(posedge core_clk_in) disable iff (!arst_n_in)
        (start_in && !busy_out && opcode_in == cce_pkg::OP_ESS &&
         src_in == dst_in) |-> ##18 (done_out && pc_load_out);
    endproperty
    a_ess_taken: assert property (p_ess_taken)
        else $error("taken branch not 18 cycles");

    property p_ess_not;
        @(posedge core_clk_in) disable iff (!arst_n_in)
        (start_in && !busy_out && opcode_in == cce_pkg::OP_ESS &&
         src_in != dst_in) |-> ##16 (done_out && !pc_load_out);
    endproperty
    a_ess_not: assert property (p_ess_not)
        else $error("untaken branch not 16 cycles");
endmodule
`default_nettype wire

/* File: hdl/cce_pkg.sv */
`default_nettype none
package cce_pkg;
    localparam logic [7:0] OP_COM_R    = 8'h60;
    localparam logic [7:0] OP_COM_PTR  = 8'h61;
    localparam logic [7:0] OP_CMP_RR   = 8'ha2;
    localparam logic [7:0] OP_CMP_RPTR = 8'ha3;
    localparam logic [7:0] OP_CMP_GR   = 8'ha4;
    localparam logic [7:0] OP_CMP_GPTR = 8'ha5;
    localparam logic [7:0] OP_CMP_LIT  = 8'ha6;
    localparam logic [7:0] OP_ESS      = 8'hc2;
    localparam logic [7:0] FLAGS_ADDR = 8'hd5;
    // flag bit positions within the flags register
    localparam int FL_C = 7;
    localparam int FL_Z = 6;
    localparam int FL_S = 5;
    localparam int FL_V = 4;
    localparam int SIGN_BIT = 7;
    localparam logic [4:0] CYC_COM   = 5'h04;
    localparam logic [4:0] CYC_CMP_S = 5'h04;
    localparam logic [4:0] CYC_CMP_L = 5'h06;
    localparam logic [4:0] CYC_ESS_T = 5'h12;
    localparam logic [4:0] CYC_ESS_N = 5'h10;
    localparam logic [1:0] LEN_COM   = 2'h2;
    localparam logic [1:0] LEN_CMP_S = 2'h2;
    localparam logic [1:0] LEN_3     = 2'h3;
    typedef enum logic [2:0] {
        CCE_IDLE = 3'h1,
        CCE_BUSY = 3'h2,
        CCE_DONE = 3'h4
    } cce_state_t;
endpackage
`default_nettype wire

/* File: hdl/cce_res_if.sv */
`timescale 1ns/100ps
`default_nettype none
// result bundle between the alu slice and the sequencer
interface cce_res_if;
    logic [7:0] result;
    logic [7:0] flags;
    logic       equal;
    logic       wr_dst;
    modport alu (output result, output flags, output equal, output wr_dst);
    modport seq (input result, input flags, input equal, input wr_dst);
endinterface
`default_nettype wire

/* File: hdl/cce_alu.sv */
`timescale 1ns/100ps
`default_nettype none
module cce_alu (
    input  wire logic [7:0] opcode_in,
    input  wire logic [7:0] dst_in,
    input  wire logic [7:0] src_in,
    input  wire logic [7:0] flags_in,
    cce_res_if.alu          res
);
    logic [8:0] diff;
    logic [7:0] inv;
    // combinational operation slice
    always_comb begin
        diff = {1'b0, dst_in} - {1'b0, src_in};
        inv = ~dst_in;
        res.flags = flags_in;
        res.result = dst_in;
        res.wr_dst = 1'b0;
        res.equal = (diff[7:0] == 8'h00);
        if (opcode_in == cce_pkg::OP_COM_R ||
            opcode_in == cce_pkg::OP_COM_PTR) begin
            res.result = inv;
            res.wr_dst = 1'b1;
            res.flags[cce_pkg::FL_Z] = (inv == 8'h00);
            res.flags[cce_pkg::FL_S] = inv[cce_pkg::SIGN_BIT];
            res.flags[cce_pkg::FL_V] = 1'b0;
        end else if (opcode_in == cce_pkg::OP_CMP_RR ||
                     opcode_in == cce_pkg::OP_CMP_RPTR ||
                     opcode_in == cce_pkg::OP_CMP_GR ||
                     opcode_in == cce_pkg::OP_CMP_GPTR ||
                     opcode_in == cce_pkg::OP_CMP_LIT) begin
            // flags only, destination stays as is
            res.flags[cce_pkg::FL_C] = diff[8];
            res.flags[cce_pkg::FL_Z] = (diff[7:0] == 8'h00);
            res.flags[cce_pkg::FL_S] = diff[cce_pkg::SIGN_BIT];
            res.flags[cce_pkg::FL_V] =
                (dst_in[cce_pkg::SIGN_BIT] != src_in[cce_pkg::SIGN_BIT]) &&
                (diff[cce_pkg::SIGN_BIT] != dst_in[cce_pkg::SIGN_BIT]);
        end
    end
endmodule
`default_nettype wire

/* File: verif/cce_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module cce_top_tb;
    logic        core_clk_in, arst_n_in, start_in;
    logic [7:0]  opcode_in, dst_in, src_in, ptr_in, jump_offset_in, flags_in;
    logic [15:0] next_pc_in, pc_out;
    logic        busy_out, done_out, illegal_out, dst_we_out, ptr_we_out;
    logic        flags_we_out, pc_load_out;
    logic [7:0]  dst_data_out, ptr_data_out, flags_data_out, flags_addr_out;
    logic [1:0]  instr_len_out;
    int          fails, tests_run, cyc, lat, n_dwe, n_fwe, n_pwe, n_pcl;
    localparam int LIMIT = 5000; // whole run needs well under 2000 cycles

    cce_top dut (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
        .start_in(start_in), .opcode_in(opcode_in), .dst_in(dst_in),
        .src_in(src_in), .ptr_in(ptr_in), .jump_offset_in(jump_offset_in),
        .flags_in(flags_in), .next_pc_in(next_pc_in), .busy_out(busy_out),
        .done_out(done_out), .illegal_out(illegal_out),
        .dst_data_out(dst_data_out), .dst_we_out(dst_we_out),
        .ptr_data_out(ptr_data_out), .ptr_we_out(ptr_we_out),
        .flags_data_out(flags_data_out), .flags_addr_out(flags_addr_out),
        .flags_we_out(flags_we_out), .pc_out(pc_out),
        .pc_load_out(pc_load_out), .instr_len_out(instr_len_out));

    // 10 MHz core clock
    always #50 core_clk_in = ~core_clk_in;

    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // hang guard: a stuck handshake ends the run as a mismatch
    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            fails++;
            stop_test();
        end
    end

    task automatic chk_bit(input string nm, input logic e, input logic s);
        tests_run++;
        if (s !== e) begin
            fails++;
            $display("unexpected %s expected %b seen %b", nm, e, s);
        end
    endtask

    task automatic chk_byte(input string nm, input logic [7:0] e,
                            input logic [7:0] s);
        tests_run++;
        if (s !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic chk_word(input string nm, input logic [15:0] e,
                            input logic [15:0] s);
        tests_run++;
        if (s !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask

    function automatic logic [7:0] exp_flags(input logic [7:0] op, d, s, f);
        logic [7:0] r;
        logic [7:0] x;
        x = f;
        if (op == cce_pkg::OP_COM_R || op == cce_pkg::OP_COM_PTR) begin
            r = ~d;
            x[cce_pkg::FL_V] = 1'b0;
        end else begin
            r = d - s;
            x[cce_pkg::FL_C] = (s > d);
            x[cce_pkg::FL_V] = (d[7] != s[7]) && (r[7] != d[7]);
        end
        x[cce_pkg::FL_Z] = (r == 8'h00);
        x[cce_pkg::FL_S] = r[7];
        return x;
    endfunction

    // one instruction: issue, count cycles and strobes up to done, compare
    task automatic do_case(input logic [7:0] op, d, s, p, o, f,
                           input logic [15:0] npc, input bit poke);
        bit com, ess, tkn;
        logic [7:0] e_lat;
        com = (op == cce_pkg::OP_COM_R || op == cce_pkg::OP_COM_PTR);
        ess = (op == cce_pkg::OP_ESS);
        tkn = ess && (d == s);
        e_lat = ess ? (tkn ? 8'h11 : 8'h0f) :
                (com || op == cce_pkg::OP_CMP_RR) ? 8'h03 : 8'h05;
        @(posedge core_clk_in);
        start_in <= 1'b1;
        opcode_in <= op;
        dst_in <= d;
        src_in <= s;
        ptr_in <= p;
        jump_offset_in <= o;
        flags_in <= f;
        next_pc_in <= npc;
        @(posedge core_clk_in);
        start_in <= 1'b0;
        #1;
        chk_bit("busy", 1'b1, busy_out);
        lat = 0;
        {n_dwe, n_fwe, n_pwe, n_pcl} = '0;
        while (lat < 40) begin
            @(posedge core_clk_in);
            start_in <= (poke && lat == 2); // retrigger while busy is ignored
            #1;
            lat++;
            n_dwe += dst_we_out;
            n_fwe += flags_we_out;
            n_pwe += ptr_we_out;
            n_pcl += pc_load_out;
            if (done_out === 1'b1)
                break;
        end
        chk_byte("latency", e_lat, 8'(lat));
        chk_byte("dst writes", {7'h0, com}, 8'(n_dwe));
        if (com)
            chk_byte("dst data", ~d, dst_data_out);
        chk_byte("flag writes", {7'h0, !ess}, 8'(n_fwe));
        if (!ess) begin
            chk_byte("flags", exp_flags(op, d, s, f), flags_data_out);
            chk_byte("flags addr", 8'hd5, flags_addr_out);
        end
        chk_byte("ptr writes", {7'h0, ess}, 8'(n_pwe));
        if (ess)
            chk_byte("ptr data", p + 8'h01, ptr_data_out);
        chk_byte("pc loads", {7'h0, tkn}, 8'(n_pcl));
        if (tkn)
            chk_word("pc", npc + {{8{o[7]}}, o}, pc_out);
        chk_byte("length", (e_lat == 8'h03) ? 8'h02 :
                 (op == cce_pkg::OP_CMP_RPTR) ? 8'h02 : 8'h03,
                 {6'h00, instr_len_out});
        @(posedge core_clk_in);
        #1;
        chk_bit("idle after done", 1'b0, busy_out);
    endtask

    logic [7:0] cp_ops [5] = '{8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6};
    logic [7:0] cp_d   [5] = '{8'h02, 8'h05, 8'h80, 8'h7f, 8'h7f};
    logic [7:0] cp_s   [5] = '{8'h03, 8'h0a, 8'h01, 8'h7f, 8'h80};

    initial begin
        core_clk_in = 1'b0;
        arst_n_in = 1'b0;
        {start_in, opcode_in, dst_in, src_in, ptr_in} = '0;
        {jump_offset_in, flags_in, next_pc_in} = '0;
        {fails, tests_run, cyc} = '0;
        repeat (6) @(posedge core_clk_in);
        // release on the edge; outputs keep reset values until the next one
        arst_n_in <= 1'b1;
        #1;
        chk_byte("flags addr at reset", 8'hd5, flags_addr_out);
        chk_bit("busy at reset", 1'b0, busy_out);
        $display("test reset done");
        // invert: plain, pointer form, all-ones to zero, carry kept
        do_case(8'h60, 8'h07, 8'h00, 8'h00, 8'h00, 8'h8f, 16'h0, 0);
        do_case(8'h61, 8'hf1, 8'h00, 8'h00, 8'h00, 8'h10, 16'h0, 0);
        do_case(8'h60, 8'hff, 8'h00, 8'h00, 8'h00, 8'h70, 16'h0, 0);
        $display("test invert done");
        // every compare encoding against borrow, overflow and zero cases
        foreach (cp_ops[i])
            foreach (cp_d[j])
                do_case(cp_ops[i], cp_d[j], cp_s[j], 8'h00, 8'h00,
                        8'h0c ^ {i[1:0], j[1:0], 4'h0}, 16'h0,
                        (i == 4 && j == 0));
        $display("test compare done");
        // equal-skip-step: taken forward, not taken, taken backward with wrap
        do_case(8'hc2, 8'h02, 8'h02, 8'h03, 8'h7f, 8'hf0, 16'h1000,
                1);
        do_case(8'hc2, 8'h02, 8'h04, 8'hff, 8'h80, 8'hf0, 16'h2000, 0);
        do_case(8'hc2, 8'h5a, 8'h5a, 8'hff, 8'h80, 8'h00, 16'h0005, 0);
        $display("test equal skip step done");
        // unknown opcode is refused without going busy
        @(posedge core_clk_in);
        start_in <= 1'b1;
        opcode_in <= 8'h00;
        @(posedge core_clk_in);
        start_in <= 1'b0;
        #1;
        chk_bit("illegal", 1'b1, illegal_out);
        chk_bit("busy on illegal", 1'b0, busy_out);
        $display("test illegal done");
        stop_test();
    end
endmodule
`default_nettype wire
